// file: shared/sdl_pkg.sv
// Shared constants and types of the serial input latch
package sdl_pkg;

  // ----------------------------------------------------------------
  // Code format
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W = 12;
  localparam logic [11:0] CODE_ZERO  = 12'h000;
  localparam logic [11:0] CODE_MID   = 12'h800;
  localparam logic [11:0] CODE_FULL  = 12'hFFF;
  localparam logic [11:0] CODE_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Link pins and word length
  // ----------------------------------------------------------------
  localparam int unsigned PIN_N = 5;
  localparam int unsigned PIN_CLR = 0;
  localparam int unsigned PIN_LD = 1;
  localparam int unsigned PIN_CS = 2;
  localparam int unsigned PIN_SDI = 3;
  localparam int unsigned PIN_SCLK = 4;
  // Idle levels of the pins, loaded into the synchroniser at reset
  localparam logic [4:0] PIN_RESET = 5'h17;
  localparam logic [4:0] BITS_PER_WORD = 5'h0C;
  localparam logic [4:0] BIT_COUNT_MAX = 5'h1F;
  localparam logic [4:0] BIT_COUNT_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // Link framing state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_SEL  = 2'b10
  } sdl_link_e;

endpackage

// file: shared/sdl_stream_if.sv
// Valid/ready stream carrier between the latch and its output buffer
`timescale 1ns/1ns
interface sdl_stream_if #(
  parameter int unsigned WIDTH = 12
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: logic/sdl_pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module sdl_pin_sync #(
  parameter int unsigned    WIDTH     = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  // Pins
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // ----------------------------------------------------------------
  // One pair of flip-flops per pin
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        next_meta[gi] = pin_i[gi];
        next_sync[gi] = meta[gi];
      end

      always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          meta[gi]   <= RESET_VAL[gi];
          sync_o[gi] <= RESET_VAL[gi];
        end else begin
          meta[gi]   <= next_meta[gi];
          sync_o[gi] <= next_sync[gi];
        end
      end
    end
  endgenerate

endmodule

// file: logic/sdl_fifo.sv
// Flip-flop FIFO with a registered head word
`timescale 1ns/1ns
module sdl_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Fill and drain sides
  sdl_stream_if.snk wr,
  sdl_stream_if.src rd
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             head_valid;
  logic [WIDTH-1:0] head_data;

  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_head_valid;
  logic [WIDTH-1:0] next_head_data;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Pointer and head control
  // ----------------------------------------------------------------
  always_comb begin
    push            = wr.valid && (count != (AW+1)'(DEPTH));
    pop             = (count != '0) && (!head_valid || rd.ready);
    next_wr_ptr     = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr     = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count      = count + (AW+1)'(push) - (AW+1)'(pop);
    next_head_valid = head_valid;
    next_head_data  = head_data;
    if (pop) begin
      next_head_valid = 1'b1;
      next_head_data  = mem[rd_ptr];
    end else if (rd.ready) begin
      next_head_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      head_valid <= 1'b0;
      head_data  <= '0;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      head_valid <= next_head_valid;
      head_data  <= next_head_data;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = head_valid;
  assign rd.data  = head_data;

endmodule

// file: logic/sdl_input_latch.sv
// Serial input latch: shift register, output code register and code stream
`timescale 1ns/1ns
module sdl_input_latch #(
  parameter int unsigned CODE_W     = sdl_pkg::CODE_W,
  parameter int unsigned FIFO_DEPTH = sdl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Serial link pins
  input  wire logic              serial_clk_i,
  input  wire logic              serial_data_in_i,
  input  wire logic              chip_sel_n_i,
  input  wire logic              load_strobe_n_i,
  input  wire logic              async_clear_n_i,
  // Output code register
  output logic      [CODE_W-1:0] dac_code_o,
  output logic                   dac_update_o,
  // Word framing status
  output logic      [4:0]        bit_count_o,
  output logic                   word_complete_o,
  // Buffered stream of code changes
  output logic                   code_valid_o,
  output logic      [CODE_W-1:0] code_data_o,
  input  wire logic              code_ready_i,
  output logic                   code_drop_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [sdl_pkg::PIN_N-1:0] pins_raw;
  logic [sdl_pkg::PIN_N-1:0] pins_sync;
  logic                      s_sclk;
  logic                      s_sdi;
  logic                      s_cs_n;
  logic                      s_ld_n;
  logic                      s_clr_n;

  always_comb begin
    pins_raw                    = '0;
    pins_raw[sdl_pkg::PIN_SCLK] = serial_clk_i;
    pins_raw[sdl_pkg::PIN_SDI]  = serial_data_in_i;
    pins_raw[sdl_pkg::PIN_CS]   = chip_sel_n_i;
    pins_raw[sdl_pkg::PIN_LD]   = load_strobe_n_i;
    pins_raw[sdl_pkg::PIN_CLR]  = async_clear_n_i;
  end

  sdl_pin_sync #(
    .WIDTH     (sdl_pkg::PIN_N),
    .RESET_VAL (sdl_pkg::PIN_RESET)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (pins_raw),
    .sync_o    (pins_sync)
  );

  assign s_sclk  = pins_sync[sdl_pkg::PIN_SCLK];
  assign s_sdi   = pins_sync[sdl_pkg::PIN_SDI];
  assign s_cs_n  = pins_sync[sdl_pkg::PIN_CS];
  assign s_ld_n  = pins_sync[sdl_pkg::PIN_LD];
  assign s_clr_n = pins_sync[sdl_pkg::PIN_CLR];

  // ----------------------------------------------------------------
  // Edge detection on the synchronised pins
  // ----------------------------------------------------------------
  logic prev_sclk;
  logic prev_ld_n;
  logic next_prev_sclk;
  logic next_prev_ld_n;
  logic sclk_rise;
  logic ld_fall;

  always_comb begin
    next_prev_sclk = s_sclk;
    next_prev_ld_n = s_ld_n;
    sclk_rise      = s_sclk && !prev_sclk;
    ld_fall        = !s_ld_n && prev_ld_n;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      prev_sclk <= 1'b1;
      prev_ld_n <= 1'b1;
    end else begin
      prev_sclk <= next_prev_sclk;
      prev_ld_n <= next_prev_ld_n;
    end
  end

  // ----------------------------------------------------------------
  // Shift register and output code register
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] shift_reg;
  logic [CODE_W-1:0] dac_code;
  logic              dac_update;
  logic [CODE_W-1:0] next_shift_reg;
  logic [CODE_W-1:0] next_dac_code;
  logic              next_dac_update;
  logic              shift_en;

  always_comb begin
    shift_en       = sclk_rise && !s_cs_n;
    next_shift_reg = shift_reg;
    if (shift_en) begin
      // Oldest bit ends up in the top position
      next_shift_reg = {shift_reg[CODE_W-2:0], s_sdi};
    end

    next_dac_code = dac_code;
    if (!s_clr_n) begin
      next_dac_code = sdl_pkg::CODE_ZERO;
    end else if (!s_ld_n) begin
      // Covers the falling edge and the transparent phase alike
      next_dac_code = next_shift_reg;
    end
    next_dac_update = (next_dac_code != dac_code);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      shift_reg  <= sdl_pkg::CODE_RESET;
      dac_code   <= sdl_pkg::CODE_RESET;
      dac_update <= 1'b0;
    end else begin
      shift_reg  <= next_shift_reg;
      dac_code   <= next_dac_code;
      dac_update <= next_dac_update;
    end
  end

  assign dac_code_o   = dac_code;
  assign dac_update_o = dac_update;

  // ----------------------------------------------------------------
  // Word framing: bits counted since chip select or the load strobe last fell
  // ----------------------------------------------------------------
  sdl_pkg::sdl_link_e link_state;
  sdl_pkg::sdl_link_e next_link_state;
  logic [4:0]         bit_count;
  logic [4:0]         next_bit_count;
  logic               word_complete;
  logic               next_word_complete;

  always_comb begin
    next_link_state = link_state;
    next_bit_count  = bit_count;
    case (link_state)
      sdl_pkg::LINK_IDLE: begin
        if (!s_cs_n) begin
          next_link_state = sdl_pkg::LINK_SEL;
          next_bit_count  = sdl_pkg::BIT_COUNT_RESET;
        end
      end
      sdl_pkg::LINK_SEL: begin
        if (s_cs_n) begin
          next_link_state = sdl_pkg::LINK_IDLE;
        end else if (shift_en && bit_count != sdl_pkg::BIT_COUNT_MAX) begin
          next_bit_count = bit_count + 5'h01;
        end
      end
      default: begin
        next_link_state = sdl_pkg::LINK_IDLE;
        next_bit_count  = sdl_pkg::BIT_COUNT_RESET;
      end
    endcase
    // A falling load edge starts a new word count
    if (ld_fall) begin
      next_bit_count = sdl_pkg::BIT_COUNT_RESET;
    end
    next_word_complete = (next_bit_count == sdl_pkg::BITS_PER_WORD);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      link_state    <= sdl_pkg::LINK_IDLE;
      bit_count     <= sdl_pkg::BIT_COUNT_RESET;
      word_complete <= 1'b0;
    end else begin
      link_state    <= next_link_state;
      bit_count     <= next_bit_count;
      word_complete <= next_word_complete;
    end
  end

  assign bit_count_o     = bit_count;
  assign word_complete_o = word_complete;

  // ----------------------------------------------------------------
  // Pending code change waiting for buffer space
  // ----------------------------------------------------------------
  sdl_stream_if #(.WIDTH(CODE_W)) fill_if ();
  sdl_stream_if #(.WIDTH(CODE_W)) drain_if ();

  logic              pend_valid;
  logic [CODE_W-1:0] pend_data;
  logic              drop;
  logic              next_pend_valid;
  logic [CODE_W-1:0] next_pend_data;
  logic              next_drop;
  logic              pend_taken;

  always_comb begin
    pend_taken      = pend_valid && fill_if.ready;
    next_pend_valid = pend_valid;
    next_pend_data  = pend_data;
    next_drop       = drop;
    if (next_dac_update) begin
      // A full buffer stalls the pending slot; a newer code then overwrites it
      if (pend_valid && !fill_if.ready) begin
        next_drop = 1'b1;
      end
      next_pend_valid = 1'b1;
      next_pend_data  = next_dac_code;
    end else if (pend_taken) begin
      next_pend_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pend_valid <= 1'b0;
      pend_data  <= sdl_pkg::CODE_RESET;
      drop       <= 1'b0;
    end else begin
      pend_valid <= next_pend_valid;
      pend_data  <= next_pend_data;
      drop       <= next_drop;
    end
  end

  assign fill_if.valid = pend_valid;
  assign fill_if.data  = pend_data;
  assign code_drop_o   = drop;

  // ----------------------------------------------------------------
  // Code buffer
  // ----------------------------------------------------------------
  sdl_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .wr        (fill_if.snk),
    .rd        (drain_if.src)
  );

  assign drain_if.ready = code_ready_i;
  assign code_valid_o   = drain_if.valid;
  assign code_data_o    = drain_if.data;

endmodule

// file: verification/sdl_input_latch_assertions.sv
// Concurrent checks on the ports of the serial input latch
`timescale 1ns/1ns
module sdl_latch_checker #(
  parameter int unsigned CODE_W     = 12,
  parameter int unsigned FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic              sys_clk_i,
  input wire logic              nrst_i,
  // Link pins
  input wire logic              serial_clk_i,
  input wire logic              serial_data_in_i,
  input wire logic              chip_sel_n_i,
  input wire logic              load_strobe_n_i,
  input wire logic              async_clear_n_i,
  // Outputs
  input wire logic [CODE_W-1:0] dac_code_o,
  input wire logic              dac_update_o,
  input wire logic [4:0]        bit_count_o,
  input wire logic              word_complete_o,
  input wire logic              code_valid_o,
  input wire logic [CODE_W-1:0] code_data_o,
  input wire logic              code_ready_i,
  input wire logic              code_drop_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // -----------------------------------------------------------
  // Properties
  // -----------------------------------------------------------
  property p_clear_zero;
    !async_clear_n_i [*2] |-> ##2 dac_code_o == 12'h000;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("code not zero in clear");
  property p_hold_code;
    (load_strobe_n_i && async_clear_n_i) [*5] |-> $stable(dac_code_o);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("code moved with load high");
  property p_load_start;
    $fell(load_strobe_n_i) && async_clear_n_i && chip_sel_n_i |-> ##3 bit_count_o == 5'h00;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not restart count");
  property p_update_flag;
    dac_update_o == $changed(dac_code_o);
  endproperty
  a_update_flag: assert property (p_update_flag) else $error("update flag wrong");
  property p_word_flag;
    word_complete_o == (bit_count_o == 5'h0C);
  endproperty
  a_word_flag: assert property (p_word_flag) else $error("word flag wrong");
  property p_count_step;
    $changed(bit_count_o) |-> bit_count_o == 5'h00 || bit_count_o == $past(bit_count_o) + 5'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");
  property p_desel_hold;
    (chip_sel_n_i && load_strobe_n_i) [*5] |-> $stable(bit_count_o);
  endproperty
  a_desel_hold: assert property (p_desel_hold) else $error("shift while deselected");
  property p_stream_hold;
    code_valid_o && !code_ready_i |=> code_valid_o && $stable(code_data_o);
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream word dropped");
  property p_drop_sticky;
    code_drop_o |=> code_drop_o;
  endproperty
  a_drop_sticky: assert property (p_drop_sticky) else $error("drop flag fell");
  c_word: cover property (word_complete_o);
  c_transparent: cover property (!load_strobe_n_i && dac_update_o);
  c_drop: cover property ($rose(code_drop_o));
endmodule

bind sdl_input_latch sdl_latch_checker #(.CODE_W(CODE_W), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .serial_clk_i(serial_clk_i),
  .serial_data_in_i(serial_data_in_i), .chip_sel_n_i(chip_sel_n_i),
  .load_strobe_n_i(load_strobe_n_i), .async_clear_n_i(async_clear_n_i),
  .dac_code_o(dac_code_o), .dac_update_o(dac_update_o), .bit_count_o(bit_count_o),
  .word_complete_o(word_complete_o), .code_valid_o(code_valid_o),
  .code_data_o(code_data_o), .code_ready_i(code_ready_i), .code_drop_o(code_drop_o));

// file: verification/sdl_host_model.sv
// Host side of the serial link: shifts words and drives load and clear
`timescale 1ns/1ns
module sdl_host_model (
  // Link pins
  output logic sclk_o,
  output logic sdi_o,
  output logic cs_n_o,
  output logic ld_n_o,
  output logic clr_n_o
);
  initial begin
    sclk_o  = 1'b1;
    sdi_o   = 1'b0;
    cs_n_o  = 1'b1;
    ld_n_o  = 1'b1;
    clr_n_o = 1'b1;
  end
  // Serial clock idles high; every task returns on the phase it was called at
  // Select and clock are toggled from their idle levels, so each frame returns them there
  task automatic shift(input logic [11:0] w);
    #7 cs_n_o = ~cs_n_o;
    #80;
    for (int i = 11; i >= 0; i--) begin
      sclk_o = ~sclk_o;
      sdi_o = w[i];
      #80 sclk_o = ~sclk_o;
      #80;
    end
    cs_n_o = ~cs_n_o;
    sdi_o = ~sdi_o;
    #73;
  endtask
  // A given number of clock pulses while deselected, which must not shift
  task automatic stray(input int unsigned n);
    #7 sdi_o = ~sdi_o;
    repeat (n) begin
      sclk_o = ~sclk_o;
      #80 sclk_o = ~sclk_o;
      #80;
    end
    #13;
  endtask
  // Load and clear move only with chip select high
  task automatic set_ld(input logic v);
    #7 ld_n_o = v;
    #153;
  endtask
  task automatic set_clr(input logic v);
    #7 clr_n_o = v;
    #153;
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the serial input latch
`timescale 1ns/1ns
module tb;
  logic        sys_clk_i;
  logic        nrst_i;
  logic        code_ready_i;
  logic        hold_ready;
  logic        sclk, serial_data_in, cs_n, ld_n, clr_n;
  logic [11:0] dac_code_o;
  logic [11:0] code_data_o;
  logic [4:0]  bit_count_o;
  logic        dac_update_o, word_complete_o, code_valid_o, code_drop_o;
  logic [11:0] sr, dac, w;
  logic [11:0] exp_q[$];
  logic [11:0] codes[6] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF, 12'h801, 12'hA5C};
  int          fails, tests_run, cycles;
  int          seed = 32'h49527878;

  sdl_host_model i_host (.sclk_o(sclk), .sdi_o(serial_data_in), .cs_n_o(cs_n), .ld_n_o(ld_n),
    .clr_n_o(clr_n));
  sdl_input_latch i_sdl_input_latch (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .serial_clk_i(sclk), .serial_data_in_i(serial_data_in),
    .chip_sel_n_i(cs_n), .load_strobe_n_i(ld_n), .async_clear_n_i(clr_n),
    .dac_code_o(dac_code_o), .dac_update_o(dac_update_o), .bit_count_o(bit_count_o),
    .word_complete_o(word_complete_o), .code_valid_o(code_valid_o),
    .code_data_o(code_data_o), .code_ready_i(code_ready_i), .code_drop_o(code_drop_o));

  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Each change of the output code becomes one stream word unless a newer code overwrites it in the pending slot
  task automatic note(input logic [11:0] v);
    if (v !== dac) exp_q.push_back(v);
    dac = v;
  endtask
  task automatic load();
    note(sr);
    i_host.set_ld(1'b0);
    check("dac_code", sr, dac_code_o);
    i_host.set_ld(1'b1);
  endtask
  task automatic drain();
    repeat (800) if (exp_q.size() != 0) @(posedge sys_clk_i);
    check("queue_left", 12'h000, 12'(exp_q.size()));
  endtask
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    code_ready_i <= !hold_ready && ($random(seed) & 1);
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // Stream monitor
  always @(posedge sys_clk_i) begin
    if (nrst_i === 1'b1 && code_valid_o === 1'b1 && code_ready_i === 1'b1) begin
      check("stream_word", exp_q.size() ? exp_q.pop_front() : 12'hXXX, code_data_o);
    end
  end

  initial begin
    nrst_i = 1'b0;
    code_ready_i = 1'b0;
    hold_ready = 1'b0;
    sr = 12'h000;
    dac = 12'h000;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    check("reset_code", 12'h000, dac_code_o);
    check("reset_flags", 12'h000, {8'h00, code_valid_o, code_drop_o, dac_update_o, 1'b0});
    foreach (codes[i]) begin
      sr = codes[i];
      i_host.shift(sr);
      i_host.stray(($random(seed) & 3) + 1);
      check("held_code", dac, dac_code_o);
      check("word_done", 12'h001, {11'h000, word_complete_o});
      load();
    end
    w = 12'h3C6;
    i_host.set_ld(1'b0);
    for (int i = 11; i >= 0; i--) begin
      sr = {sr[10:0], w[i]};
      note(sr);
    end
    i_host.shift(w);
    check("follow_code", w, dac_code_o);
    i_host.set_ld(1'b1);
    note(12'h000);
    i_host.set_clr(1'b0);
    check("clear_code", 12'h000, dac_code_o);
    i_host.set_ld(1'b0);
    i_host.set_ld(1'b1);
    i_host.set_clr(1'b1);
    check("after_clear", 12'h000, dac_code_o);
    load();
    i_host.set_ld(1'b0);
    note(12'h000);
    i_host.set_clr(1'b0);
    check("clear_transp", 12'h000, dac_code_o);
    note(sr);
    i_host.set_clr(1'b1);
    check("release_code", sr, dac_code_o);
    i_host.set_ld(1'b1);
    drain();
    hold_ready = 1'b1;
    repeat (35) begin
      sr = 12'($random(seed));
      if (sr === dac) sr = ~sr;
      i_host.shift(sr);
      load();
    end
    exp_q.delete(33);
    check("drop_flag", 12'h001, {11'h000, code_drop_o});
    hold_ready = 1'b0;
    drain();
    print_verdict();
  end
endmodule
